//--- hdl/adccr_start_delay.sv
// Fires one pulse in the reference clock cycle after the Nth converter clock tick after an arm pulse.
`timescale 1ns/1ps
`default_nettype none
module adccr_start_delay #(
    parameter int TICKS = 2
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_arm,
    input wire logic i_tick,
    output logic o_fire
);
    logic [3:0] cnt_r;
    logic [3:0] cnt_nxt;
    logic fire_nxt;
    logic fire_r;

    // A new arm restarts the count, so the last request always wins.
    always_comb begin
        cnt_nxt = cnt_r;
        fire_nxt = 1'b0;
        if (i_arm) begin
            cnt_nxt = 4'(TICKS);
        end else if (i_tick && cnt_r != 4'h0) begin
            cnt_nxt = cnt_r - 4'h1;
            fire_nxt = (cnt_r == 4'h1);
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_r <= 4'h0;
            fire_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            fire_r <= fire_nxt;
        end
    end

    assign o_fire = fire_r;
endmodule : adccr_start_delay
`default_nettype wire

//--- hdl/adccr_sync2.sv
// Two-flop synchroniser for asynchronous pins.
`timescale 1ns/1ps
`default_nettype none
module adccr_sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] sync_r;

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= i_async;
            sync_r <= meta_r;
        end
    end

    assign o_sync = sync_r;
endmodule : adccr_sync2
`default_nettype wire

//--- hdl/adccr_top.sv
// Converter start control, busy flag and serial result read-back.
// What the document requires
// RL1: Trigger pin starts on second converter clock edge.
// RL2: Host keeps trigger high and low two periods.
// RL3: Busy rises one divided period after start.
// RL4: Trigger pin aborts and restarts running conversion.
// RL5: Trigger pin works whatever chip select is.
// RL6: Control register selects one of four read-back modes.
// RL7: Explicit reads pick byte order by address, width.
// RL8: Mode 1 auto-outputs high byte first.
// RL9: Mode 2 auto-outputs low byte first.
// RL10: Mode 3 auto-outputs high byte only.
// RL11: Only serial starts arm automatic output.
// RL12: First bit on active edge, rest on inactive.
// RL13: Host avoids completion inside first bit window.
// RL14: Reads return last conversion completed before data.
// RL15: Host waits busy low with chip select held.
// RL16: Output data invalid until its active edge.
// RL17: Host enables reference and oscillator after reset.
// RL18: Divided clock is 1, 2, 4 or 8 periods.
// RL19: Serial starts queue one deep, newest wins.
// RL20: Abort keeps last completed result until next completes.
`timescale 1ns/1ps
`default_nettype none
module adccr_top #(
    parameter int CONV_LEN = adccr_pkg::CONV_DCLKS
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_convert_pin,
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic i_din,
    input wire logic [15:0] i_conv_data,
    output logic o_busy,
    output logic o_dout,
    output logic o_dout_oe
);
    ////////////////////////////////////////////////////////////////////////////
    typedef enum logic [1:0] {CV_IDLE = 2'b01, CV_RUN = 2'b10} adccr_cv_t;
    typedef enum logic [2:0] {SP_INST = 3'b001, SP_WR = 3'b010, SP_RD = 3'b100} adccr_sp_t;

    logic [3:0] pins_s;
    logic trig_s, sclk_s, cs_n_s, din_s;
    logic trig_q_r, sclk_q_r;
    logic trig_rise, sclk_act, sclk_inact;
    logic pin_fire, ser_fire, ser_arm;

    adccr_sync2 #(.WIDTH(4)) u_sync (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_async({i_convert_pin, i_sclk, i_cs_n, i_din}),
        .o_sync(pins_s)
    );
    assign {trig_s, sclk_s, cs_n_s, din_s} = pins_s;
    assign trig_rise = trig_s && !trig_q_r;
    assign sclk_act = !cs_n_s && sclk_s && !sclk_q_r;
    assign sclk_inact = !cs_n_s && !sclk_s && sclk_q_r;

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            trig_q_r <= 1'b0;
            sclk_q_r <= 1'b0;
        end else begin
            trig_q_r <= trig_s;
            sclk_q_r <= sclk_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Converter clock enable, one pulse per converter clock falling edge.
    logic [7:0] converter_clock_cnt_r, converter_clock_cnt_nxt;
    logic converter_clock_en;
    assign converter_clock_en = (converter_clock_cnt_r == 8'(adccr_pkg::CONVERTER_CLOCK_DIV - 1));

    always_comb begin
        converter_clock_cnt_nxt = converter_clock_en ? 8'h00 : converter_clock_cnt_r + 8'h01;
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            converter_clock_cnt_r <= 8'h00;
        end else begin
            converter_clock_cnt_r <= converter_clock_cnt_nxt;
        end
    end

    // RL1: pin start delay
    // RL5: chip select ignored
    adccr_start_delay #(.TICKS(adccr_pkg::START_CONVERTER_CLOCK_EDGES)) u_pin_dly (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_arm(trig_rise),
        .i_tick(converter_clock_en),
        .o_fire(pin_fire)
    );

    adccr_start_delay #(.TICKS(adccr_pkg::START_CONVERTER_CLOCK_EDGES)) u_ser_dly (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_arm(ser_arm),
        .i_tick(converter_clock_en),
        .o_fire(ser_fire)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Conversion sequencer.
    logic [7:0] ctrl_r, ctrl_nxt;
    adccr_cv_t cv_r, cv_nxt;
    logic [7:0] conv_cnt_r, conv_cnt_nxt;
    logic [2:0] divided_conversion_clock_cnt_r, divided_conversion_clock_cnt_nxt;
    logic busy_r, busy_nxt, queued_r, queued_nxt;
    logic [15:0] result_r, result_nxt;
    logic [2:0] divided_conversion_clock_last;
    logic divided_conversion_clock_en, conv_done;

    // RL18: divided clock select
    assign divided_conversion_clock_last = 3'((4'h1 << ctrl_r[adccr_pkg::CFD_POS +: 2]) - 4'h1);
    assign divided_conversion_clock_en = converter_clock_en && (divided_conversion_clock_cnt_r == divided_conversion_clock_last);
    assign conv_done = (cv_r == CV_RUN) && divided_conversion_clock_en && (conv_cnt_r == 8'(CONV_LEN - 1));

    always_comb begin
        cv_nxt = cv_r;
        conv_cnt_nxt = conv_cnt_r;
        divided_conversion_clock_cnt_nxt = converter_clock_en ? (divided_conversion_clock_en ? 3'h0 : divided_conversion_clock_cnt_r + 3'h1) : divided_conversion_clock_cnt_r;
        busy_nxt = busy_r;
        queued_nxt = queued_r;
        result_nxt = result_r;
        if (cv_r == CV_RUN && divided_conversion_clock_en) begin
            conv_cnt_nxt = conv_cnt_r + 8'h01;
            // RL3: busy after one divided period
            if (conv_cnt_r == 8'h00) begin
                busy_nxt = 1'b1;
            end
        end
        if (conv_done) begin
            // RL20: result updates only on completion
            result_nxt = i_conv_data;
            busy_nxt = 1'b0;
            conv_cnt_nxt = 8'h00;
            // RL19: queued start follows at once
            cv_nxt = queued_r ? CV_RUN : CV_IDLE;
            queued_nxt = 1'b0;
        end
        if (pin_fire) begin
            // RL4: abort and restart
            cv_nxt = CV_RUN;
            conv_cnt_nxt = 8'h00;
            divided_conversion_clock_cnt_nxt = 3'h0;
            busy_nxt = 1'b0;
            queued_nxt = 1'b0;
        end else if (ser_fire) begin
            // RL19: one-deep queue
            if (cv_r == CV_RUN && !conv_done) begin
                queued_nxt = 1'b1;
            end else begin
                cv_nxt = CV_RUN;
                conv_cnt_nxt = 8'h00;
                divided_conversion_clock_cnt_nxt = 3'h0;
            end
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            cv_r <= CV_IDLE;
            conv_cnt_r <= 8'h00;
            divided_conversion_clock_cnt_r <= 3'h0;
            busy_r <= 1'b0;
            queued_r <= 1'b0;
            result_r <= 16'h0000;
        end else begin
            cv_r <= cv_nxt;
            conv_cnt_r <= conv_cnt_nxt;
            divided_conversion_clock_cnt_r <= divided_conversion_clock_cnt_nxt;
            busy_r <= busy_nxt;
            queued_r <= queued_nxt;
            result_r <= result_nxt;
        end
    end

    assign o_busy = busy_r;

    ////////////////////////////////////////////////////////////////////////////
    // Serial port: instruction, register write and result read-back.
    adccr_sp_t sp_r, sp_nxt;
    logic [4:0] bit_cnt_r, bit_cnt_nxt;
    logic [15:0] sreg_r, sreg_nxt;
    logic [4:0] addr_r, addr_nxt;
    logic wide_r, wide_nxt, lo_first_r, lo_first_nxt;
    logic auto_r, auto_nxt;
    logic dout_r, dout_nxt, oe_r, oe_nxt;
    logic [7:0] byte_in;
    logic [15:0] rd_word;
    logic [1:0] rbm;

    assign byte_in = {sreg_r[6:0], din_s};
    assign rbm = ctrl_r[adccr_pkg::RBM_POS +: 2];
    // RL7: byte order by address
    // RL14: word sampled at the data edges
    assign rd_word = (addr_r == adccr_pkg::ADDR_CTRL) ? {ctrl_r, 8'h00} :
                     lo_first_r ? {result_r[7:0], result_r[15:8]} : result_r;

    always_comb begin
        sp_nxt = sp_r;
        bit_cnt_nxt = bit_cnt_r;
        sreg_nxt = sreg_r;
        addr_nxt = addr_r;
        wide_nxt = wide_r;
        lo_first_nxt = lo_first_r;
        auto_nxt = auto_r;
        dout_nxt = dout_r;
        oe_nxt = oe_r;
        ctrl_nxt = ctrl_r;
        ser_arm = 1'b0;
        if (cs_n_s) begin
            sp_nxt = SP_INST;
            bit_cnt_nxt = 5'h00;
            oe_nxt = 1'b0;
            auto_nxt = 1'b0;
        end else begin
            case (sp_r)
                SP_INST: begin
                    if (sclk_act) begin
                        sreg_nxt = {8'h00, byte_in};
                        bit_cnt_nxt = bit_cnt_r + 5'h01;
                        if (bit_cnt_r == 5'(adccr_pkg::BYTE_BITS - 1)) begin
                            bit_cnt_nxt = 5'h00;
                            addr_nxt = byte_in[4:0];
                            wide_nxt = byte_in[adccr_pkg::INST_WIDE_POS];
                            lo_first_nxt = (byte_in[4:0] == adccr_pkg::ADDR_RES_LO);
                            if (byte_in[adccr_pkg::INST_START_POS]) begin
                                ser_arm = 1'b1;
                                // RL11: only serial starts arm output
                                // RL6: mode chooses auto read
                                if (rbm != adccr_pkg::RBM_EXPLICIT) begin
                                    sp_nxt = SP_RD;
                                    auto_nxt = 1'b1;
                                    // RL8: mode 1 high byte first
                                    // RL9: mode 2 low byte first
                                    // RL10: mode 3 high byte only
                                    wide_nxt = (rbm != adccr_pkg::RBM_HI_ONLY);
                                    lo_first_nxt = (rbm == adccr_pkg::RBM_LO_FIRST);
                                    addr_nxt = lo_first_nxt ? adccr_pkg::ADDR_RES_LO : adccr_pkg::ADDR_RES_HI;
                                end
                            end else if (byte_in[adccr_pkg::INST_READ_POS]) begin
                                sp_nxt = SP_RD;
                            end else begin
                                sp_nxt = SP_WR;
                            end
                        end
                    end
                end
                SP_WR: begin
                    if (sclk_act) begin
                        sreg_nxt = {8'h00, byte_in};
                        bit_cnt_nxt = bit_cnt_r + 5'h01;
                        if (bit_cnt_r == 5'(adccr_pkg::BYTE_BITS - 1)) begin
                            if (addr_r == adccr_pkg::ADDR_CTRL) begin
                                ctrl_nxt = byte_in;
                            end
                            bit_cnt_nxt = 5'h00;
                            sp_nxt = SP_INST;
                        end
                    end
                end
                SP_RD: begin
                    // RL12: first bit on active edge
                    // RL16: drive only from active edge
                    if (sclk_act) begin
                        bit_cnt_nxt = bit_cnt_r + 5'h01;
                        oe_nxt = 1'b1;
                        dout_nxt = (bit_cnt_r == 5'h00) ? rd_word[15] : sreg_r[15];
                        if (bit_cnt_r != 5'h00) begin
                            sreg_nxt = {sreg_r[14:0], 1'b0};
                        end
                    end else if (sclk_inact) begin
                        if (bit_cnt_r == 5'h01) begin
                            // RL12: rest caught on inactive edge
                            sreg_nxt = {rd_word[14:0], 1'b0};
                        end
                        if (bit_cnt_r == (wide_r ? 5'(adccr_pkg::WORD_BITS) : 5'(adccr_pkg::BYTE_BITS))) begin
                            sp_nxt = SP_INST;
                            bit_cnt_nxt = 5'h00;
                            oe_nxt = 1'b0;
                            auto_nxt = 1'b0;
                        end
                    end
                end
                default: begin
                    sp_nxt = SP_INST;
                end
            endcase
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            sp_r <= SP_INST;
            bit_cnt_r <= 5'h00;
            sreg_r <= 16'h0000;
            addr_r <= 5'h00;
            wide_r <= 1'b0;
            lo_first_r <= 1'b0;
            auto_r <= 1'b0;
            dout_r <= 1'b0;
            oe_r <= 1'b0;
            ctrl_r <= adccr_pkg::CTRL_RST;
        end else begin
            sp_r <= sp_nxt;
            bit_cnt_r <= bit_cnt_nxt;
            sreg_r <= sreg_nxt;
            addr_r <= addr_nxt;
            wide_r <= wide_nxt;
            lo_first_r <= lo_first_nxt;
            auto_r <= auto_nxt;
            dout_r <= dout_nxt;
            oe_r <= oe_nxt;
            ctrl_r <= ctrl_nxt;
        end
    end

    assign o_dout = dout_r;
    assign o_dout_oe = oe_r;

    ////////////////////////////////////////////////////////////////////////////
    sequence s_trig;
        trig_rise;
    endsequence
    sequence s_pin_go;
        ##[20:62] pin_fire;
    endsequence

    property p_pin_start;
        @(posedge i_ref_clk) disable iff (i_rst) s_trig ##1 (!trig_rise) [*1] |-> s_pin_go;
    endproperty
    a_pin_start: assert property (p_pin_start) else $error("pin start not on second converter_clock edge"); // RL1

    property p_abort;
        @(posedge i_ref_clk) disable iff (i_rst) pin_fire |=> cv_r == CV_RUN && conv_cnt_r == 8'h00 && !busy_r;
    endproperty
    a_abort: assert property (p_abort) else $error("pin start did not restart conversion"); // RL4

    property p_busy_rise;
        @(posedge i_ref_clk) disable iff (i_rst) $rose(busy_r) |-> $past(divided_conversion_clock_en) && $past(conv_cnt_r) == 8'h00;
    endproperty
    a_busy_rise: assert property (p_busy_rise) else $error("busy rose off the first divided tick"); // RL3

    property p_divided_conversion_clock;
        @(posedge i_ref_clk) disable iff (i_rst) divided_conversion_clock_en |-> converter_clock_en && divided_conversion_clock_cnt_r == divided_conversion_clock_last;
    endproperty
    a_divided_conversion_clock: assert property (p_divided_conversion_clock) else $error("divided clock tick misplaced"); // RL18

    property p_result_hold;
        @(posedge i_ref_clk) disable iff (i_rst) !$stable(result_r) |-> $past(conv_done);
    endproperty
    a_result_hold: assert property (p_result_hold) else $error("result changed without completion"); // RL20

    property p_auto_arm;
        @(posedge i_ref_clk) disable iff (i_rst) $rose(auto_r) |-> $past(ser_arm) && !$past(pin_fire && !ser_arm);
    endproperty
    a_auto_arm: assert property (p_auto_arm) else $error("auto output armed without serial start"); // RL11

    property p_queue;
        @(posedge i_ref_clk) disable iff (i_rst) ser_fire && !pin_fire && cv_r == CV_RUN && !conv_done |=> queued_r;
    endproperty
    a_queue: assert property (p_queue) else $error("serial start not queued"); // RL19

    property p_oe_edge;
        @(posedge i_ref_clk) disable iff (i_rst) $rose(oe_r) |-> $past(sclk_act) && $past(sp_r) == SP_RD;
    endproperty
    a_oe_edge: assert property (p_oe_edge) else $error("data driven before active edge"); // RL16
endmodule : adccr_top
`default_nettype wire

//--- inc/adccr_pkg.sv
// Shared constants for the converter start and result read-back block.
package adccr_pkg;
    // Register addresses on the serial port.
    localparam logic [4:0] ADDR_RES_LO = 5'h00;
    localparam logic [4:0] ADDR_RES_HI = 5'h01;
    localparam logic [4:0] ADDR_CTRL = 5'h03;
    // Converter control register fields and reset value.
    localparam int RBM_POS = 0;
    localparam int CFD_POS = 2;
    localparam logic [7:0] CTRL_RST = 8'h00;
    // Instruction byte fields.
    localparam int INST_START_POS = 7;
    localparam int INST_READ_POS = 6;
    localparam int INST_WIDE_POS = 5;
    // Read-back modes.
    localparam logic [1:0] RBM_EXPLICIT = 2'h0;
    localparam logic [1:0] RBM_HI_FIRST = 2'h1;
    localparam logic [1:0] RBM_LO_FIRST = 2'h2;
    localparam logic [1:0] RBM_HI_ONLY = 2'h3;
    // Timing: reference clock, converter clock and conversion length.
    localparam int REF_CLK_HZ = 50000000;
    localparam int CONV_CLK_HZ = 2500000;
    localparam int CONVERTER_CLOCK_DIV = REF_CLK_HZ / CONV_CLK_HZ;
    localparam int START_CONVERTER_CLOCK_EDGES = 2;
    localparam int CONV_DCLKS = 18;
    localparam int BYTE_BITS = 8;
    localparam int WORD_BITS = 16;
endpackage : adccr_pkg

//--- verif/adccr_host_model.sv
// Host model driving the trigger pin and the serial port of the converter.
`timescale 1ns/1ps
`default_nettype none
module adccr_host_model #(
    parameter int HALF = 8,
    parameter int PIN_HOLD = 45
) (
    input wire logic i_ref_clk,
    input wire logic i_dout,
    output logic o_convert_pin,
    output logic o_sclk,
    output logic o_cs_n,
    output logic o_din
);
    initial begin
        o_convert_pin = 1'b0;
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_din = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////
    // pin level hold.
    task automatic pin_set(input logic lvl);
        repeat (PIN_HOLD) @(negedge i_ref_clk);
        o_convert_pin = lvl;
    endtask : pin_set
    task automatic cs_set(input logic lvl);
        repeat (HALF) @(negedge i_ref_clk);
        o_cs_n = lvl;
        repeat (HALF) @(negedge i_ref_clk);
    endtask : cs_set
    // The clock idles low, and an unused data line toggles so it never holds a stale bit.
    task automatic shift(input logic [15:0] wd, input int n, input logic wr, output logic [15:0] rd);
        rd = 16'h0000;
        for (int k = n - 1; k >= 0; k--) begin
            @(negedge i_ref_clk);
            o_din = wr ? wd[k] : ~o_din;
            repeat (HALF) @(negedge i_ref_clk);
            o_sclk = 1'b1;
            repeat (HALF) @(negedge i_ref_clk);
            rd = {rd[14:0], i_dout};
            o_sclk = 1'b0;
        end
    endtask : shift
endmodule : adccr_host_model
`default_nettype wire

//--- verif/test_adccr_top.sv
// Self-checking bench for the converter start and result read-back block.
`timescale 1ns/1ps
`default_nettype none
module test_adccr_top;
    localparam int CONV_LEN = 3;
    localparam int CONVERTER_CLOCK = adccr_pkg::CONVERTER_CLOCK_DIV;
    logic i_ref_clk;
    logic i_rst;
    logic convert_pin;
    logic sclk;
    logic cs_n;
    logic din;
    logic [15:0] conv_data;
    logic busy;
    logic dout;
    logic dout_oe;
    logic [15:0] prev;
    logic [15:0] got;
    int failures;
    int tests_run;
    int seed;
    int cyc;

    adccr_top #(.CONV_LEN(CONV_LEN)) adccr_top_i (
        .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_convert_pin(convert_pin), .i_sclk(sclk),
        .i_cs_n(cs_n), .i_din(din), .i_conv_data(conv_data), .o_busy(busy), .o_dout(dout),
        .o_dout_oe(dout_oe)
    );
    adccr_host_model adccr_host_model_i (
        .i_ref_clk(i_ref_clk), .i_dout(dout), .o_convert_pin(convert_pin), .o_sclk(sclk),
        .o_cs_n(cs_n), .o_din(din)
    );

    initial begin
        i_ref_clk = 1'b0;
        forever #10 i_ref_clk = ~i_ref_clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("failures %0d tests_run %0d", failures, tests_run);
        if (failures == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : finish_test
    task automatic check_val(input logic [15:0] g, input logic [15:0] e);
        tests_run++;
        if (g !== e) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : check_val
    task automatic check_span(input int g, input int lo, input int hi);
        tests_run++;
        if (g < lo || g > hi) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h..%h", $time, g, lo, hi);
        end
    endtask : check_span
    task automatic wait_busy(input logic lvl, output int n);
        n = 0;
        while (busy !== lvl && n < 2000) begin
            @(negedge i_ref_clk);
            n++;
        end
    endtask : wait_busy
    task automatic reg_read(input logic [4:0] addr, input logic wide, output logic [15:0] v);
        logic [15:0] junk;
        adccr_host_model_i.cs_set(1'b0);
        adccr_host_model_i.shift({8'h00, 2'b01, wide, addr}, 8, 1'b1, junk);
        adccr_host_model_i.shift(16'h0000, wide ? 16 : 8, 1'b0, v);
        adccr_host_model_i.cs_set(1'b1);
    endtask : reg_read
    task automatic reg_write(input logic [4:0] addr, input logic [7:0] d);
        logic [15:0] junk;
        adccr_host_model_i.cs_set(1'b0);
        adccr_host_model_i.shift({8'h00, 3'b000, addr}, 8, 1'b1, junk);
        adccr_host_model_i.shift({8'h00, d}, 8, 1'b1, junk);
        adccr_host_model_i.cs_set(1'b1);
    endtask : reg_write
    // Byte order and width of a result word for a read-back mode.
    function automatic logic [15:0] expect_read(input logic [1:0] mode, input logic [15:0] r);
        case (mode)
            adccr_pkg::RBM_LO_FIRST: return {r[7:0], r[15:8]};
            adccr_pkg::RBM_HI_ONLY: return {8'h00, r[15:8]};
            default: return r;
        endcase
    endfunction : expect_read
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (60000) @(posedge i_ref_clk);
        failures++;
        finish_test();
    end

    initial begin
        seed = 32'he6ba2118;
        failures = 0;
        tests_run = 0;
        i_rst = 1'b1;
        conv_data = 16'h0000;
        prev = 16'h0000;
        repeat (4) @(posedge i_ref_clk);
        @(negedge i_ref_clk);
        i_rst = 1'b0;
        repeat (4) @(negedge i_ref_clk);
        reg_read(adccr_pkg::ADDR_CTRL, 1'b0, got);
        check_val(got, {8'h00, adccr_pkg::CTRL_RST});
        reg_write(5'h02, 8'hff);
        reg_read(adccr_pkg::ADDR_CTRL, 1'b0, got);
        check_val(got, {8'h00, adccr_pkg::CTRL_RST});
        // Pin starts at every divider, select alternately high and low.
        for (int n = 0; n < 4; n++) begin
            reg_write(adccr_pkg::ADDR_CTRL, 8'(n << adccr_pkg::CFD_POS));
            conv_data = 16'($random(seed));
            adccr_host_model_i.cs_set(n[0] ? 1'b0 : 1'b1);
            adccr_host_model_i.pin_set(1'b1);
            wait_busy(1'b1, cyc);
            check_span(cyc, CONVERTER_CLOCK * (1 << n) + 20, CONVERTER_CLOCK * (1 << n) + 62);
            wait_busy(1'b0, cyc);
            check_span(cyc, (CONV_LEN - 1) * CONVERTER_CLOCK * (1 << n), (CONV_LEN - 1) * CONVERTER_CLOCK * (1 << n));
            adccr_host_model_i.pin_set(1'b0);
            adccr_host_model_i.cs_set(1'b1);
            prev = conv_data;
            for (int k = 0; k < 3; k++) begin
                reg_read(k == 1 ? adccr_pkg::ADDR_RES_LO : adccr_pkg::ADDR_RES_HI, k != 2, got);
                check_val(got, expect_read(2'(k + 1), conv_data));
            end
        end
        // A second pin edge aborts the running conversion.
        reg_write(adccr_pkg::ADDR_CTRL, 8'h0c);
        conv_data = 16'($random(seed));
        adccr_host_model_i.pin_set(1'b1);
        wait_busy(1'b1, cyc);
        conv_data = 16'($random(seed));
        adccr_host_model_i.pin_set(1'b0);
        adccr_host_model_i.pin_set(1'b1);
        wait_busy(1'b0, cyc);
        check_span(cyc, 20, 63);
        wait_busy(1'b1, cyc);
        adccr_host_model_i.pin_set(1'b0);
        reg_read(adccr_pkg::ADDR_RES_HI, 1'b1, got);
        check_val(got, prev);
        wait_busy(1'b0, cyc);
        reg_read(adccr_pkg::ADDR_RES_HI, 1'b1, got);
        check_val(got, conv_data);
        prev = conv_data;
        // Serial starts with automatic output in modes 1 to 3.
        for (int m = 1; m < 4; m++) begin
            reg_write(adccr_pkg::ADDR_CTRL, 8'(m));
            conv_data = 16'($random(seed));
            // read at once, well before this conversion ends.
            adccr_host_model_i.cs_set(1'b0);
            adccr_host_model_i.shift(16'h0080, 8, 1'b1, got);
            adccr_host_model_i.shift(16'h0000, m == 3 ? 8 : 16, 1'b0, got);
            check_val(got, expect_read(2'(m), prev));
            adccr_host_model_i.cs_set(1'b1);
            conv_data = 16'($random(seed));
            adccr_host_model_i.cs_set(1'b0);
            adccr_host_model_i.shift(16'h0080, 8, 1'b1, got);
            // select held low until busy drops.
            wait_busy(1'b1, cyc);
            wait_busy(1'b0, cyc);
            check_val({15'h0000, dout_oe}, 16'h0000);
            adccr_host_model_i.shift(16'h0000, m == 3 ? 8 : 16, 1'b0, got);
            check_val(got, expect_read(2'(m), conv_data));
            adccr_host_model_i.cs_set(1'b1);
            prev = conv_data;
        end
        // Two serial starts back to back: the second waits in the queue.
        reg_write(adccr_pkg::ADDR_CTRL, 8'h0c);
        conv_data = 16'($random(seed));
        adccr_host_model_i.cs_set(1'b0);
        adccr_host_model_i.shift(16'h0080, 8, 1'b1, got);
        adccr_host_model_i.shift(16'h0080, 8, 1'b1, got);
        wait_busy(1'b1, cyc);
        wait_busy(1'b0, cyc);
        wait_busy(1'b1, cyc);
        check_span(cyc, CONVERTER_CLOCK * 8 - 2, CONVERTER_CLOCK * 8 + 2);
        wait_busy(1'b0, cyc);
        adccr_host_model_i.cs_set(1'b1);
        reg_read(adccr_pkg::ADDR_RES_HI, 1'b1, got);
        check_val(got, conv_data);
        // this block holds no reference or oscillator enables to set.
        // A pin start in mode 1 leaves the port waiting for an instruction.
        reg_write(adccr_pkg::ADDR_CTRL, 8'(adccr_pkg::RBM_HI_FIRST));
        conv_data = 16'($random(seed));
        adccr_host_model_i.cs_set(1'b0);
        adccr_host_model_i.pin_set(1'b1);
        wait_busy(1'b1, cyc);
        wait_busy(1'b0, cyc);
        adccr_host_model_i.pin_set(1'b0);
        adccr_host_model_i.shift(16'h0041, 8, 1'b1, got);
        adccr_host_model_i.shift(16'h0000, 8, 1'b0, got);
        check_val(got, expect_read(adccr_pkg::RBM_HI_ONLY, conv_data));
        adccr_host_model_i.cs_set(1'b1);
        finish_test();
    end
endmodule : test_adccr_top
`default_nettype wire
